// ==== verilog/pcuerr_log.sv ====
// internal error logging bank four: status word, wishbone slave, event interrupt
// assumes fault events are single-cycle pulses on clk; same clock domain
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module pcuerr_log
  import pcuerr_pkg::*;
#(
  parameter logic [31:0] IDENT_VALUE = IDENT_DEFAULT
)
(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  clkEn,
  input  wire pcuerr_pkg::pcuerr_event_t faultEvents,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  output logic                       irq
);
  import pcuerr_pkg::*;

  logic [63:0] status_reg;
  logic        logEnable_reg;
  logic [2:0]  irqStat_reg;
  logic [2:0]  irqMask_reg;
  logic [31:0] wbDat_reg;
  logic        wbAck_reg;
  logic        wbErr_reg;
  logic        irq_reg;
  logic [2:0]  irqStat_next;
  logic [63:0] status_next;
  logic [3:0]  ucCode;
  logic [3:0]  fsmCode;
  logic        anyEvent;
  logic        logEvent;
  logic        busReq;
  logic        wrAcc;
  logic        rdAcc;
  logic        mapped;
  logic        clearStatus;
  logic        readIrqStat;
  logic [31:0] rdData;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  pcuerr_encode u_encode (
    .events   (faultEvents),
    .ucCode   (ucCode),
    .fsmCode  (fsmCode),
    .anyEvent (anyEvent)
  );

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // new request only while ack is low, so each access answers once
  assign busReq = wb_cyc_i & wb_stb_i & ~wbAck_reg & ~wbErr_reg;
  assign wrAcc  = busReq & wb_we_i;
  assign rdAcc  = busReq & ~wb_we_i;
  assign mapped = hit(wb_adr_i, STATUS_LO_OFF) | hit(wb_adr_i, STATUS_HI_OFF) |
                  hit(wb_adr_i, CONTROL_OFF) | hit(wb_adr_i, IRQ_STAT_OFF) |
                  hit(wb_adr_i, IRQ_MASK_OFF) | hit(wb_adr_i, IDENT_OFF);
  assign clearStatus = wrAcc & hit(wb_adr_i, CONTROL_OFF) & wb_sel_i[1] & wb_dat_i[8];
  assign readIrqStat = rdAcc & hit(wb_adr_i, IRQ_STAT_OFF);
  assign logEvent    = anyEvent & logEnable_reg;

  // ----------------------------------------
  // status word capture
  // ----------------------------------------
  always_comb
  begin
    status_next = status_reg;
    if (clearStatus)
      status_next = STATUS_RESET;
    if (logEvent)
    begin
      if (status_next[VALID_BIT])
        status_next[OVER_BIT] = 1'b1;
      status_next[VALID_BIT] = 1'b1;
      // firmware wins the class when both arrive together
      status_next[CLASS_MSB:CLASS_LSB] = faultEvents.firmware ? CLASS_FIRMWARE
                                                              : CLASS_PCU;
      status_next[UCF_MSB:UCF_LSB]     = ucCode;
      status_next[FSMF_MSB:FSMF_LSB]   = fsmCode;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      status_reg <= STATUS_RESET;
    else if (clkEn)
      status_reg <= status_next;
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      logEnable_reg <= 1'b1;
    else if (clkEn && wrAcc && hit(wb_adr_i, CONTROL_OFF) && wb_sel_i[0])
      logEnable_reg <= wb_dat_i[0];
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  // bit0 hardware microcontroller, bit1 state machine, bit2 firmware
  always_comb
  begin
    irqStat_next = irqStat_reg;
    if (readIrqStat)
      irqStat_next = IRQ_RESET;
    // set beats clear-on-read in the same cycle
    if (logEnable_reg)
      irqStat_next = irqStat_next |
                     {faultEvents.firmware, |faultEvents.fsmFault, |faultEvents.ucFault};
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irqStat_reg <= IRQ_RESET;
    else if (clkEn)
      irqStat_reg <= irqStat_next;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irqMask_reg <= IRQ_RESET;
    else if (clkEn && wrAcc && hit(wb_adr_i, IRQ_MASK_OFF) && wb_sel_i[0])
      irqMask_reg <= wb_dat_i[2:0];
  end

  // registered from the next status value, so it rises with the status bit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_reg <= 1'b0;
    else if (clkEn)
      irq_reg <= |(irqStat_next & irqMask_reg);
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb
  begin
    rdData = 32'h0000_0000;
    case (wb_adr_i)
      STATUS_LO_OFF: rdData = status_reg[31:0];
      STATUS_HI_OFF: rdData = status_reg[63:32];
      CONTROL_OFF:   rdData = {31'h0000_0000, logEnable_reg};
      IRQ_STAT_OFF:  rdData = {29'h0000_0000, irqStat_reg};
      IRQ_MASK_OFF:  rdData = {29'h0000_0000, irqMask_reg};
      IDENT_OFF:     rdData = IDENT_VALUE;
      default:       rdData = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  // one wait state: ack the cycle after the strobe, drop it the next
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wbAck_reg <= 1'b0;
      wbErr_reg <= 1'b0;
      wbDat_reg <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      wbAck_reg <= busReq & mapped;
      wbErr_reg <= busReq & ~mapped;
      if (rdAcc)
        wbDat_reg <= mapped ? rdData : 32'h0000_0000;
    end
  end

  assign wb_dat_o = wbDat_reg;
  assign wb_ack_o = wbAck_reg;
  assign wb_err_o = wbErr_reg;
  assign irq      = irq_reg;
endmodule
`default_nettype wire

// ==== verilog/pcuerr_pkg.sv ====
// package for the internal error logging block: offsets, codes, field layout, reset values
// assumes a classic wishbone slave with 32-bit data and byte addresses
package pcuerr_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] STATUS_LO_OFF = 8'h00;
  localparam logic [7:0] STATUS_HI_OFF = 8'h04;
  localparam logic [7:0] CONTROL_OFF   = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFF  = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFF  = 8'h10;
  localparam logic [7:0] IDENT_OFF     = 8'h14;

  // ----------------------------------------
  // field layout of the status word
  // ----------------------------------------
  localparam int CLASS_LSB = 0;
  localparam int CLASS_MSB = 15;
  localparam int UCF_LSB   = 16;
  localparam int UCF_MSB   = 19;
  localparam int FSMF_LSB  = 20;
  localparam int FSMF_MSB  = 23;
  localparam int VALID_BIT = 63;
  localparam int OVER_BIT  = 62;

  // ----------------------------------------
  // class codes
  // ----------------------------------------
  localparam logic [15:0] CLASS_PCU      = 16'h0402;
  localparam logic [15:0] CLASS_FIRMWARE = 16'h0406;

  // ----------------------------------------
  // microcontroller fault codes
  // ----------------------------------------
  localparam logic [3:0] UC_NONE       = 4'h0;
  localparam logic [3:0] UC_INSTR_ADDR = 4'h1;
  localparam logic [3:0] UC_INSTR_DBE  = 4'h2;
  localparam logic [3:0] UC_BAD_OPCODE = 4'h3;
  localparam logic [3:0] UC_STACK_UNF  = 4'h4;
  localparam logic [3:0] UC_STACK_OVF  = 4'h5;
  localparam logic [3:0] UC_DATA_ADDR  = 4'h6;
  localparam logic [3:0] UC_DATA_DBE   = 4'h7;

  // ----------------------------------------
  // state-machine fault codes
  // ----------------------------------------
  localparam logic [3:0] FSM_NONE      = 4'h0;
  localparam logic [3:0] FSM_TIMEOUT   = 4'h4;
  localparam logic [3:0] FSM_SMB_INT   = 4'h5;
  localparam logic [3:0] FSM_BAD_TRANS = 4'h9;

  // ----------------------------------------
  // reset values and widths
  // ----------------------------------------
  localparam logic [63:0] STATUS_RESET  = 64'h0000_0000_0000_0000;
  localparam logic [2:0]  IRQ_RESET     = 3'h0;
  localparam logic [31:0] IDENT_DEFAULT = 32'h0000_A5A5;  // arbitrary value
  localparam int          UC_EVENTS     = 7;
  localparam int          FSM_EVENTS    = 3;

  // one-hot event inputs, bit i = code list position i + 1 (position 0 is the none code)
  typedef struct packed {
    logic                  firmware;
    logic [UC_EVENTS-1:0]  ucFault;
    logic [FSM_EVENTS-1:0] fsmFault;
  } pcuerr_event_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } pcuerr_wb_req_t;

endpackage

// ==== verilog/pcuerr_encode.sv ====
// priority encoder from one-hot fault events to the logged field codes
// assumes one-hot or simultaneous events; lowest index wins
`timescale 1ns/10ps
`default_nettype none
module pcuerr_encode
  import pcuerr_pkg::*;
(
  input  wire pcuerr_pkg::pcuerr_event_t events,
  output logic [3:0]                     ucCode,
  output logic [3:0]                     fsmCode,
  output logic                           anyEvent
);
  import pcuerr_pkg::*;

  // ----------------------------------------
  // microcontroller field
  // ----------------------------------------
  always_comb
  begin
    ucCode = UC_NONE;
    if (events.ucFault[0])
      ucCode = UC_INSTR_ADDR;
    else if (events.ucFault[1])
      ucCode = UC_INSTR_DBE;
    else if (events.ucFault[2])
      ucCode = UC_BAD_OPCODE;
    else if (events.ucFault[3])
      ucCode = UC_STACK_UNF;
    else if (events.ucFault[4])
      ucCode = UC_STACK_OVF;
    else if (events.ucFault[5])
      ucCode = UC_DATA_ADDR;
    else if (events.ucFault[6])
      ucCode = UC_DATA_DBE;
  end

  // ----------------------------------------
  // state-machine field
  // ----------------------------------------
  always_comb
  begin
    fsmCode = FSM_NONE;
    if (events.fsmFault[0])
      fsmCode = FSM_TIMEOUT;
    else if (events.fsmFault[1])
      fsmCode = FSM_SMB_INT;
    else if (events.fsmFault[2])
      fsmCode = FSM_BAD_TRANS;
  end

  assign anyEvent = events.firmware | (|events.ucFault) | (|events.fsmFault);
endmodule
`default_nettype wire

// ==== verification/pcuerr_log_chk.sv ====
// checker for the bank four error logging block, ports only
// assumes a classic wishbone master that drops stb after each answer
`timescale 1ns/10ps
`default_nettype none
module pcuerr_log_chk
  import pcuerr_pkg::*;
#(
  parameter logic [31:0] IDENT_VALUE = IDENT_DEFAULT
)
(
  input wire logic                      clk,
  input wire logic                      reset_n,
  input wire logic                      clkEn,
  input wire pcuerr_pkg::pcuerr_event_t faultEvents,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_we_i,
  input wire logic [3:0]                wb_sel_i,
  input wire logic [7:0]                wb_adr_i,
  input wire logic [31:0]               wb_dat_i,
  input wire logic [31:0]               wb_dat_o,
  input wire logic                      wb_ack_o,
  input wire logic                      wb_err_o,
  input wire logic                      irq
);
  import pcuerr_pkg::*;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o & clkEn;
  wire mapped = wb_adr_i inside {STATUS_LO_OFF, STATUS_HI_OFF, CONTROL_OFF,
                                 IRQ_STAT_OFF, IRQ_MASK_OFF, IDENT_OFF};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence rdLo;
    req && !wb_we_i && wb_adr_i == STATUS_LO_OFF;
  endsequence
  AST_CLASS: assert property (rdLo |=> wb_dat_o[15:0] inside {16'h0000, 16'h0402, 16'h0406})
    else $error("class code out of set");
  AST_UCF: assert property (rdLo |=> wb_dat_o[19:16] <= 4'h7)
    else $error("uc field reserved value");
  AST_FSMF: assert property (rdLo |=> wb_dat_o[23:20] inside {4'h0, 4'h4, 4'h5, 4'h9})
    else $error("fsm field reserved value");
  AST_ACK: assert property (req && mapped |=> wb_ack_o && !wb_err_o)
    else $error("no ack for mapped access");
  AST_ERR: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
    else $error("no err for unmapped access");
  // a refused write leaves the last read data in place, only reads return zero
  AST_ERRDAT: assert property (req && !mapped && !wb_we_i |=> wb_dat_o == 32'h0)
    else $error("unmapped read data not zero");
  AST_IDENT: assert property (req && !wb_we_i && wb_adr_i == IDENT_OFF |=> wb_dat_o == IDENT_VALUE)
    else $error("ident read wrong");
  AST_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_CAUSE: assert property (wb_ack_o || wb_err_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("answer without request");
  AST_FREEZE: assert property (!clkEn |=> $stable(irq) && $stable(wb_dat_o))
    else $error("state moved with clock enable low");
endmodule
bind pcuerr_log pcuerr_log_chk #(.IDENT_VALUE(IDENT_VALUE)) u_chk (.clk(clk), .reset_n(reset_n),
  .clkEn(clkEn), .faultEvents(faultEvents), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irq(irq));
`default_nettype wire

// ==== verification/pcuerr_log_tb.sv ====
// bench for the bank four error logging block over wishbone
// assumes one 100 MHz clock; events are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module pcuerr_log_tb;
  import pcuerr_pkg::*;
  logic          clk = 0;
  logic          reset_n = 0;
  logic          clkEn = 1;
  pcuerr_event_t ev = '0;
  pcuerr_event_t e;
  logic          cyc = 0;
  logic          stb = 0;
  logic          we = 0;
  logic [3:0]    sel = 0;
  logic [7:0]    adr = 0;
  logic [31:0]   wdat = 0;
  logic [31:0]   rdat;
  logic          ack;
  logic          err;
  logic          irq;
  logic [31:0]   d;
  logic          er;
  logic [3:0]    fsmTab [3] = '{4'h4, 4'h5, 4'h9};
  int            error_cnt = 0;
  int            n_tests = 0;
  always #5 clk = ~clk;
  pcuerr_log uut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .faultEvents(ev),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .irq(irq));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      error_cnt++;
    end
  endtask
  // hold the request until an answer is sampled high at a rising edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     input logic [3:0] s, output logic [31:0] r, output logic e1);
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, wd, s};
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
    r = rdat;
    e1 = err;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    acc(1'b0, a, 32'h0, 4'hF, r, er);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
    acc(1'b1, a, wd, s, d, er);
  endtask
  task automatic pulse(input pcuerr_event_t p);
    @(posedge clk);
    ev <= p;
    @(posedge clk);
    ev <= '0;
  endtask
  task automatic results;
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    results;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1;
    rd(STATUS_LO_OFF, d);
    check("lo", d, 32'h0);
    rd(CONTROL_OFF, d);
    check("ctl", d, 32'h1);
    wr(IDENT_OFF, 32'h0, 4'hF);
    rd(IDENT_OFF, d);
    check("id", d, IDENT_DEFAULT);
    wr(8'h18, 32'h1, 4'hF);
    check("werr", {31'h0, er}, 32'h1);
    rd(8'h18, d);
    check("rerr", {31'h0, er}, 32'h1);
    check("rdz", d, 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      e = '0;
      e.ucFault[i] = 1'b1;
      pulse(e);
      rd(STATUS_LO_OFF, d);
      check("uc", d, {8'h0, 4'h0, 4'(i + 1), 16'h0402});
      check("ucf", {28'h0, d[19:16]}, 32'(i + 1));
      rd(STATUS_HI_OFF, d);
      check("hi", d, (i == 0) ? 32'h8000_0000 : 32'hC000_0000);
    end
    wr(CONTROL_OFF, 32'h101, 4'h3);
    rd(STATUS_LO_OFF, d);
    check("clr", d, 32'h0);
    rd(STATUS_HI_OFF, d);
    check("clrh", d, 32'h0);
    for (int j = 0; j < 3; j++)
    begin
      e = '0;
      e.fsmFault[j] = 1'b1;
      pulse(e);
      rd(STATUS_LO_OFF, d);
      check("fsm", d, {8'h0, fsmTab[j], 4'h0, 16'h0402});
    end
    e = '0;
    e.firmware = 1'b1;
    e.ucFault = 7'h24;
    e.fsmFault = 3'h6;
    pulse(e);
    rd(STATUS_LO_OFF, d);
    check("fw", d, {8'h0, 4'h5, 4'h3, 16'h0406});
    rd(IRQ_STAT_OFF, d);
    check("ist", d, 32'h7);
    rd(IRQ_STAT_OFF, d);
    check("ist0", d, 32'h0);
    // clear and disable logging in one write
    wr(CONTROL_OFF, 32'h100, 4'h3);
    pulse(e);
    rd(STATUS_LO_OFF, d);
    check("off", d, 32'h0);
    wr(CONTROL_OFF, 32'h1, 4'h1);
    @(posedge clk);
    {clkEn, ev} <= {1'b0, e};
    @(posedge clk);
    {clkEn, ev} <= {1'b1, 11'h0};
    rd(STATUS_LO_OFF, d);
    check("frz", d, 32'h0);
    wr(IRQ_MASK_OFF, 32'h1, 4'h1);
    rd(IRQ_MASK_OFF, d);
    check("msk", d, 32'h1);
    e = '0;
    e.ucFault[0] = 1'b1;
    pulse(e);
    repeat (2) @(posedge clk);
    #1 check("irq", {31'h0, irq}, 32'h1);
    rd(IRQ_STAT_OFF, d);
    check("ist1", d, 32'h1);
    @(posedge clk);
    #1 check("irq0", {31'h0, irq}, 32'h0);
    e = '0;
    e.fsmFault[0] = 1'b1;
    pulse(e);
    repeat (2) @(posedge clk);
    #1 check("irqm", {31'h0, irq}, 32'h0);
    rd(IRQ_STAT_OFF, d);
    check("ist2", d, 32'h2);
    results;
  end
endmodule
`default_nettype wire
